// ---- hw/i2c_dac_defines.svh ----
// Constants shared by both ends of the two-wire converter link.
// Assumes it is included by bare name after the package is compiled.
`ifndef I2C_DAC_DEFINES_SVH
`define I2C_DAC_DEFINES_SVH

// Fixed upper part of the seven-bit slave address.
`define DAC_ADDR_FIXED 5'h03

// Command codes carried in the high nibble of the command byte.
`define CMD_NOP 4'h0
`define CMD_WRITE_INPUT 4'h1
`define CMD_UPDATE 4'h2
`define CMD_WRITE_UPDATE 4'h3
`define CMD_REF_SETUP 4'h7

// Reset state of the internal reference enable.
`define REF_EN_RESET 1'b1

// Timing: system clock in MHz and fastest serial clock in kHz.
`define CLK_MHZ 200
`define SCL_FAST_KHZ 400
// Quarter of the fastest allowed serial period, rounded up.
`define SCL_QUARTER_CYC ((`CLK_MHZ * 1000 + 4 * `SCL_FAST_KHZ - 1) / (4 * `SCL_FAST_KHZ))

// Controller register byte offsets on the AXI4-Lite slave.
`define REG_COMMAND 8'h00
`define REG_SLAVE 8'h04
`define REG_STATUS 8'h08

// Field positions and reset values of the controller registers.
`define COMMAND_READ_BIT 24
`define STATUS_BUSY_BIT 0
`define STATUS_NACK_BIT 1
`define SLAVE_ADDR_RESET 7'h0C

// AXI response codes.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- hw/i2c_dac_pkg.sv ----
// Types shared by both ends of the two-wire converter link.
// Assumes nothing of its surroundings.
package i2c_dac_pkg;
  typedef logic [15:0] code_type;
  typedef enum logic [2:0] {
    sl_idle, sl_addr, sl_write, sl_read, sl_skip
  } slave_state_type;
  typedef enum logic [1:0] {
    ms_idle, ms_start, ms_bits, ms_stop
  } master_state_type;
endpackage

// ---- hw/i2c_bus_if.sv ----
// Open-drain two-wire bus joining the controller and the converter port.
// Assumes each party drives only its own enables; a set enable pulls low.
`timescale 1ns/1ps
`default_nettype none
interface i2c_bus_if;
  logic scl_o;
  logic scl_oe;
  logic sda_o_m;
  logic sda_oe_m;
  logic sda_o_s;
  logic sda_oe_s;
  logic scl;
  logic sda;

  // Wired-AND resolution of both lines with pull-ups.
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_oe_m & ~sda_o_m) | (sda_oe_s & ~sda_o_s));

  modport master(output scl_o, scl_oe, sda_o_m, sda_oe_m, input sda);
  modport device(input scl, sda, output sda_o_s, sda_oe_s);
endinterface
`default_nettype wire

// ---- hw/i2c_dac_device.sv ----
// Serial command port of a quad voltage-output converter.
// Assumes the bus clock is far slower than aclk and is sampled, not used
// as a clock; strap and load strobe pins are asynchronous.
//
// Functional notes
// - Payload gathers into a 24-bit shift register.
// - High nibble of first byte is command.
// - Low nibble selects channels A to D.
// - Data code left-justified, low pad bits ignored.
// - Bits taken on falling edges, act after 24th.
// - Command acts on every selected channel.
// - Code 0001 writes input registers, transparent strobe.
// - Code 0010 copies input to converter register.
// - Code 0011 writes converter registers regardless strobe.
// - Address is 00011 plus two strap bits.
// - No ten-bit or general call response.
// - Bus runs at standard or fast rate.
// - Master opens each transfer with start condition.
// - Matching address acknowledged at ninth clock.
// - Nine clocks per byte, MSB first, stable high.
// - Write is address, command, two data bytes.
// - Readback: no-op pointer, repeated start, two bytes.
// - Master ends read with not-acknowledge then stop.
// - Multiple selected channels read back channel A.
// - Reference on after reset, serial write disables.
// - Each channel has input and converter registers.
// - Low strobe during 0001 updates both registers.
// - Readback sends two bytes, upper first.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_dac_defines.svh"
module i2c_dac_device #(
  parameter int RESOLUTION = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  i2c_bus_if.device bus,
  input wire logic address_strap_lsb,
  input wire logic address_strap_msb,
  input wire logic load_strobe_n,
  output var i2c_dac_pkg::code_type [3:0] input_code,
  output var i2c_dac_pkg::code_type [3:0] dac_code,
  output logic ref_enable
);
  import i2c_dac_pkg::*;

  // Clears the pad bits below a narrower code.
  localparam code_type CODE_MASK = code_type'(16'hFFFF << (16 - RESOLUTION));

  logic [1:0] scl_sy;
  logic [1:0] sda_sy;
  logic [1:0] ld_sy;
  logic [1:0] lsb_sy;
  logic [1:0] msb_sy;
  logic scl_d;
  logic sda_d;
  logic ld_d;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic ld_fall;

  slave_state_type state_r;
  logic [3:0] bit_cnt_r;
  logic rose_r;
  logic master_nack_r;
  logic [23:0] shift_r;
  logic [1:0] byte_idx_r;
  logic [1:0] ptr_r;
  logic [15:0] tx_r;
  logic low_half_r;
  logic sda_oe_r;

  logic bit_fall;
  logic [23:0] word;
  logic addr_match;
  logic cmd_done;
  logic exec;
  logic [3:0] cmd;
  logic [3:0] sel;
  code_type data;
  logic [1:0] ptr_nxt;
  logic [1:0] ptr_sel;

  // Two-stage synchronisers; the extra stage only feeds edge detection.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
      ld_sy <= 2'h3;
      lsb_sy <= 2'h0;
      msb_sy <= 2'h0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      ld_d <= 1'b1;
    end else begin
      scl_sy <= {scl_sy[0], bus.scl};
      sda_sy <= {sda_sy[0], bus.sda};
      ld_sy <= {ld_sy[0], load_strobe_n};
      lsb_sy <= {lsb_sy[0], address_strap_lsb};
      msb_sy <= {msb_sy[0], address_strap_msb};
      scl_d <= scl_sy[1];
      sda_d <= sda_sy[1];
      ld_d <= ld_sy[1];
    end
  end

  assign scl_rise = scl_sy[1] & ~scl_d;
  assign scl_fall = ~scl_sy[1] & scl_d;
  // Data moving while the clock is high marks start or stop.
  assign start_seen = scl_sy[1] & scl_d & sda_d & ~sda_sy[1];
  assign stop_seen = scl_sy[1] & scl_d & ~sda_d & sda_sy[1];
  assign ld_fall = ld_d & ~ld_sy[1];

  // A falling edge counts only after a rising one, so the fall that
  // closes a start condition is not taken for a data bit.
  assign bit_fall = scl_fall & rose_r & (state_r != sl_idle) &
                    (state_r != sl_skip);
  assign word = {shift_r[22:0], sda_sy[1]};
  assign addr_match = word[7:1] ==
                      {`DAC_ADDR_FIXED, msb_sy[1], lsb_sy[1]};
  assign cmd_done = bit_fall & (bit_cnt_r == 4'd7) & (state_r == sl_write) &
                    (byte_idx_r == 2'd0);
  assign exec = bit_fall & (bit_cnt_r == 4'd7) & (state_r == sl_write) &
                (byte_idx_r == 2'd2);
  assign cmd = word[23:20];
  assign sel = word[19:16];
  assign data = word[15:0] & CODE_MASK;
  assign ptr_nxt = ptr_r + 2'd1;

  // A single select bit names the channel; several fall back to A.
  always_comb begin
    case (word[3:0])
      4'h2: ptr_sel = 2'd1;
      4'h4: ptr_sel = 2'd2;
      4'h8: ptr_sel = 2'd3;
      default: ptr_sel = 2'd0;
    endcase
  end

  // Byte framing, acknowledge and readback shifting.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= sl_idle;
      bit_cnt_r <= 4'd0;
      rose_r <= 1'b0;
      master_nack_r <= 1'b1;
      shift_r <= 24'h000000;
      byte_idx_r <= 2'd0;
      ptr_r <= 2'd0;
      tx_r <= 16'h0000;
      low_half_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (start_seen) begin
      state_r <= sl_addr;
      bit_cnt_r <= 4'd0;
      rose_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (stop_seen) begin
      state_r <= sl_idle;
      sda_oe_r <= 1'b0;
    end else begin
      if (scl_rise) begin
        rose_r <= 1'b1;
        master_nack_r <= sda_sy[1];
      end
      if (scl_fall) begin
        rose_r <= 1'b0;
      end
      if (cmd_done && word[7:4] == `CMD_NOP) begin
        ptr_r <= ptr_sel;
      end
      if (bit_fall && bit_cnt_r != 4'd8) begin
        bit_cnt_r <= bit_cnt_r + 4'd1;
        if (state_r == sl_read) begin
          tx_r <= {tx_r[14:0], 1'b0};
          sda_oe_r <= (bit_cnt_r != 4'd7) & ~tx_r[14];
        end else begin
          shift_r <= word;
        end
        if (bit_cnt_r == 4'd7 && state_r == sl_addr) begin
          // Only a seven-bit match is answered; general call and
          // ten-bit prefixes never match the fixed upper bits.
          if (addr_match) begin
            sda_oe_r <= 1'b1;
          end else begin
            state_r <= sl_skip;
          end
        end
        if (bit_cnt_r == 4'd7 && state_r == sl_write) begin
          sda_oe_r <= 1'b1;
        end
      end else if (bit_fall) begin
        bit_cnt_r <= 4'd0;
        sda_oe_r <= 1'b0;
        case (state_r)
          sl_addr: begin
            if (shift_r[0]) begin
              state_r <= sl_read;
              tx_r <= input_code[ptr_r];
              sda_oe_r <= ~input_code[ptr_r][15];
              low_half_r <= 1'b0;
            end else begin
              state_r <= sl_write;
              byte_idx_r <= 2'd0;
            end
          end
          sl_write: begin
            byte_idx_r <= (byte_idx_r == 2'd2) ? 2'd0 : byte_idx_r + 2'd1;
          end
          sl_read: begin
            // Upper byte first; the lower one is already in tx_r[15:8].
            if (master_nack_r) begin
              state_r <= sl_skip;
            end else if (low_half_r) begin
              ptr_r <= ptr_nxt;
              tx_r <= input_code[ptr_nxt];
              sda_oe_r <= ~input_code[ptr_nxt][15];
              low_half_r <= 1'b0;
            end else begin
              sda_oe_r <= ~tx_r[15];
              low_half_r <= 1'b1;
            end
          end
          default: begin
            state_r <= state_r;
          end
        endcase
      end
    end
  end

  assign bus.sda_o_s = 1'b0;
  assign bus.sda_oe_s = sda_oe_r;

  // Input and converter registers of the four channels.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_code <= '0;
      dac_code <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (exec && sel[i]) begin
          case (cmd)
            `CMD_WRITE_INPUT: begin
              input_code[i] <= data;
              if (!ld_sy[1]) begin
                dac_code[i] <= data;
              end
            end
            `CMD_UPDATE: begin
              dac_code[i] <= input_code[i];
            end
            `CMD_WRITE_UPDATE: begin
              input_code[i] <= data;
              dac_code[i] <= data;
            end
            default: begin
              dac_code[i] <= dac_code[i];
            end
          endcase
        end else if (ld_fall) begin
          dac_code[i] <= input_code[i];
        end
      end
    end
  end

  // Bit 0 of the data field set turns the reference off.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_enable <= `REF_EN_RESET;
    end else if (exec && cmd == `CMD_REF_SETUP) begin
      ref_enable <= ~word[0];
    end
  end
endmodule
`default_nettype wire

// ---- hw/i2c_dac_master.sv ----
// Bus master that writes commands to, and reads codes from, the converter.
// Assumes software orders transfers over AXI4-Lite and polls status.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_dac_defines.svh"
module i2c_dac_master #(
  parameter int QUARTER_CYC = `SCL_QUARTER_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  i2c_bus_if.master bus
);
  import i2c_dac_pkg::*;

  master_state_type mst_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [24:0] cmd_r;
  logic [6:0] slave_r;
  logic go_r;
  logic nack_r;
  logic [15:0] rx_r;
  logic [15:0] qcnt_r;
  logic [1:0] phase_r;
  logic [3:0] bitn_r;
  logic [2:0] seq_r;
  logic scl_oe_r;
  logic sda_oe_r;
  logic [1:0] sda_sy;
  logic busy;
  logic tick;
  logic rd;
  logic rx;
  logic [7:0] tx_byte;
  logic [31:0] cmd_merged;
  logic [31:0] slave_merged;
  logic [31:0] status;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  assign busy = (mst_r != ms_idle) | go_r;
  assign cmd_merged = merge({7'h00, cmd_r}, w_data_r, w_strb_r);
  assign slave_merged = merge({25'h0000000, slave_r}, w_data_r, w_strb_r);
  assign status = {rx_r, 14'h0000, nack_r, busy};

  // AXI4-Lite slave: address and data are taken in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      cmd_r <= 25'h0000000;
      slave_r <= `SLAVE_ADDR_RESET;
      go_r <= 1'b0;
    end else begin
      go_r <= 1'b0;
      if (awvalid && awready) begin
        aw_addr_r <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data_r <= wdata;
        w_strb_r <= wstrb;
        wready <= 1'b0;
      end
      if (!awready && !wready && !bvalid) begin
        bvalid <= 1'b1;
        bresp <= `RESP_OKAY;
        // A new command while a transfer runs is refused.
        if (aw_addr_r == `REG_COMMAND && !busy) begin
          cmd_r <= cmd_merged[24:0];
          go_r <= 1'b1;
        end else if (aw_addr_r == `REG_SLAVE && !busy) begin
          slave_r <= slave_merged[6:0];
        end else begin
          bresp <= `RESP_SLVERR;
        end
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= `RESP_OKAY;
      case (araddr)
        `REG_COMMAND: rdata <= {7'h00, cmd_r};
        `REG_SLAVE: rdata <= {25'h0000000, slave_r};
        `REG_STATUS: rdata <= status;
        default: begin
          rdata <= 32'h00000000;
          rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Quarter-period divider; four ticks make one serial clock.
  assign tick = qcnt_r == 16'(QUARTER_CYC - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn || mst_r == ms_idle || tick) begin
      qcnt_r <= 16'h0000;
    end else begin
      qcnt_r <= qcnt_r + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sda_sy <= 2'h3;
    end else begin
      sda_sy <= {sda_sy[0], bus.sda};
    end
  end

  assign rd = cmd_r[`COMMAND_READ_BIT];
  assign rx = rd & (seq_r >= 3'd3);
  always_comb begin
    case (seq_r)
      3'd0: tx_byte = {slave_r, 1'b0};
      3'd1: tx_byte = cmd_r[23:16];
      3'd2: tx_byte = rd ? {slave_r, 1'b1} : cmd_r[15:8];
      default: tx_byte = cmd_r[7:0];
    endcase
  end

  // Start, nine-clock bytes and stop, one quarter period per phase.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mst_r <= ms_idle;
      phase_r <= 2'd0;
      bitn_r <= 4'd0;
      seq_r <= 3'd0;
      nack_r <= 1'b0;
      rx_r <= 16'h0000;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (mst_r == ms_idle) begin
      if (go_r) begin
        mst_r <= ms_start;
        phase_r <= 2'd0;
        seq_r <= 3'd0;
        nack_r <= 1'b0;
        rx_r <= 16'h0000;
      end
    end else if (tick) begin
      phase_r <= phase_r + 2'd1;
      case (mst_r)
        ms_start: begin
          case (phase_r)
            2'd0: sda_oe_r <= 1'b0;
            2'd1: scl_oe_r <= 1'b0;
            2'd2: sda_oe_r <= 1'b1;
            default: begin
              scl_oe_r <= 1'b1;
              mst_r <= ms_bits;
              bitn_r <= 4'd0;
            end
          endcase
        end
        ms_bits: begin
          case (phase_r)
            2'd0: begin
              // Data changes only while the clock is low.
              if (bitn_r == 4'd8) begin
                sda_oe_r <= rx & (seq_r == 3'd3);
              end else begin
                sda_oe_r <= ~rx & ~tx_byte[3'(4'd7 - bitn_r)];
              end
            end
            2'd1: scl_oe_r <= 1'b0;
            2'd2: begin
              if (bitn_r != 4'd8 && rx) begin
                rx_r <= {rx_r[14:0], sda_sy[1]};
              end else if (bitn_r == 4'd8 && !rx && sda_sy[1]) begin
                nack_r <= 1'b1;
              end
            end
            default: begin
              scl_oe_r <= 1'b1;
              bitn_r <= (bitn_r == 4'd8) ? 4'd0 : bitn_r + 4'd1;
              if (bitn_r == 4'd8) begin
                if (nack_r || (!rd && seq_r == 3'd3) ||
                    (rd && seq_r == 3'd4)) begin
                  mst_r <= ms_stop;
                end else if (rd && seq_r == 3'd1) begin
                  mst_r <= ms_start;
                  seq_r <= 3'd2;
                end else begin
                  seq_r <= seq_r + 3'd1;
                end
              end
            end
          endcase
        end
        ms_stop: begin
          case (phase_r)
            2'd0: sda_oe_r <= 1'b1;
            2'd1: scl_oe_r <= 1'b0;
            2'd2: sda_oe_r <= 1'b0;
            default: mst_r <= ms_idle;
          endcase
        end
        default: mst_r <= ms_idle;
      endcase
    end
  end

  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = scl_oe_r;
  assign bus.sda_o_m = 1'b0;
  assign bus.sda_oe_m = sda_oe_r;
endmodule
`default_nettype wire

// ---- sim/i2c_dac_chk.sv ----
// Wire-level checker for the two-wire link between controller and device.
// Assumes the controller runs with a quarter period of four aclk cycles.
`timescale 1ns/1ps
`default_nettype none
module i2c_dac_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sda_oe_m,
  input wire logic sda_oe_s,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_dev_sda_sclow: assert property ($changed(sda_oe_s) |-> !scl)
    else $error("device moved data line while clock high");
  a_start_master: assert property (
    $fell(sda) && scl && $past(scl) |-> sda_oe_m)
    else $error("start not made by controller");
  a_stop_master: assert property (
    $rose(sda) && scl && $past(scl) |-> !sda_oe_s)
    else $error("stop while device holds data line");
  a_sda_hi_stable: assert property (
    $changed(sda) && scl && $past(scl) |-> $changed(sda_oe_m))
    else $error("data line moved by device during clock high");
  a_scl_high_len: assert property ($rose(scl) |-> scl[*6])
    else $error("clock high phase too short");
  a_scl_low_len: assert property ($fell(scl) |-> (!scl)[*6])
    else $error("clock low phase too short");
  a_dev_release: assert property (
    $rose(sda_oe_s) |-> ##[1:160] !sda_oe_s)
    else $error("device holds data line too long");
  a_idle_after_stop: assert property (
    $rose(sda) && scl && $past(scl) |-> scl[*4])
    else $error("clock moved right after stop");
endmodule
`default_nettype wire

// ---- sim/i2c_dac_tb.sv ----
// Self-checking bench joining controller and converter port over the bus.
// Assumes the package, defines header and bus interface are compiled.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_dac_defines.svh"
module i2c_dac_tb;
  import i2c_dac_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, ref_enable;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, st;
  logic address_strap_lsb = 1'b0, address_strap_msb = 1'b0;
  logic load_strobe_n = 1'b1;
  code_type [3:0] input_code, dac_code, exp_in, exp_dac;
  int failures = 0;
  int n_checks = 0;

  i2c_bus_if bus();
  i2c_dac_master #(.QUARTER_CYC(4)) u_i2c_dac_master (.aclk(aclk),
    .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .bus(bus));
  i2c_dac_device #(.RESOLUTION(16)) u_i2c_dac_device (.aclk(aclk),
    .aresetn(aresetn), .bus(bus), .address_strap_lsb(address_strap_lsb),
    .address_strap_msb(address_strap_msb), .load_strobe_n(load_strobe_n),
    .input_code(input_code), .dac_code(dac_code), .ref_enable(ref_enable));
  i2c_dac_chk u_i2c_dac_chk (.aclk(aclk), .aresetn(aresetn),
    .sda_oe_m(bus.sda_oe_m), .sda_oe_s(bus.sda_oe_s), .scl(bus.scl),
    .sda(bus.sda));

  always #2.5 aclk = ~aclk;

  task automatic check(input string name, input logic [63:0] seen,
                       input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    if (failures == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    st = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic idle();
    int n;
    n = 0;
    do begin
      axi_rd(`REG_STATUS);
      n++;
    end while (st[0] !== 1'b0 && n < 2000);
    check("busy", st[0], 1'b0);
  endtask

  task automatic xfer(input logic rd, input logic [3:0] c,
                      input logic [3:0] s, input logic [15:0] d);
    axi_wr(`REG_COMMAND, {7'h00, rd, c, s, d});
    check("cmd_resp", rs, `RESP_OKAY);
    idle();
  endtask

  task automatic cmp();
    check("input", input_code, exp_in);
    check("dac", dac_code, exp_dac);
  endtask

  task automatic t_reset();
    check("ref", ref_enable, 1'b1);
    cmp();
    axi_rd(`REG_SLAVE);
    check("slave", st, 32'h0C);
  endtask

  // Every strap setting answers; general call, 10-bit prefix and
  // wrong addresses must all go unacknowledged and leave codes alone.
  task automatic t_addr();
    logic [6:0] bad [4];
    bad = '{7'h00, 7'h78, 7'h0D, 7'h1C};
    for (int i = 0; i < 4; i++) begin
      address_strap_lsb <= i[0];
      address_strap_msb <= i[1];
      axi_wr(`REG_SLAVE, {25'h0, `DAC_ADDR_FIXED, i[1:0]});
      xfer(1'b0, `CMD_WRITE_UPDATE, 4'b0001, {14'h0400, i[1:0]});
      exp_in[0] = {14'h0400, i[1:0]};
      exp_dac[0] = exp_in[0];
      check("ack", st[1], 1'b0);
      cmp();
    end
    address_strap_lsb <= 1'b0;
    address_strap_msb <= 1'b0;
    foreach (bad[i]) begin
      axi_wr(`REG_SLAVE, {25'h0, bad[i]});
      xfer(1'b0, `CMD_WRITE_UPDATE, 4'b1111, 16'hFFFF);
      check("nack", st[1], 1'b1);
      cmp();
    end
    axi_wr(`REG_SLAVE, 32'h0C);
  endtask

  task automatic t_write();
    xfer(1'b0, `CMD_WRITE_INPUT, 4'b0101, 16'h1234);
    exp_in[0] = 16'h1234;
    exp_in[2] = 16'h1234;
    cmp();
    xfer(1'b0, `CMD_UPDATE, 4'b0001, 16'h0000);
    exp_dac[0] = exp_in[0];
    cmp();
    load_strobe_n <= 1'b0;
    repeat (8) @(posedge aclk);
    exp_dac = exp_in;
    cmp();
    xfer(1'b0, `CMD_WRITE_INPUT, 4'b0010, 16'h5555);
    exp_in[1] = 16'h5555;
    exp_dac[1] = 16'h5555;
    cmp();
    load_strobe_n <= 1'b1;
    xfer(1'b0, `CMD_WRITE_UPDATE, 4'b1110, 16'hABCD);
    for (int i = 1; i < 4; i++) begin
      exp_in[i] = 16'hABCD;
      exp_dac[i] = 16'hABCD;
    end
    cmp();
  endtask

  task automatic t_read();
    xfer(1'b0, `CMD_WRITE_INPUT, 4'b1000, 16'h0F0F);
    exp_in[3] = 16'h0F0F;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, `CMD_NOP, 4'(1 << i), 16'h0000);
      check("readback", st[31:16], exp_in[i]);
    end
    xfer(1'b1, `CMD_NOP, 4'b1100, 16'h0000);
    check("multi", st[31:16], exp_in[0]);
    cmp();
  endtask

  task automatic t_ref();
    xfer(1'b0, `CMD_REF_SETUP, 4'b0000, 16'h0001);
    check("ref_off", ref_enable, 1'b0);
    xfer(1'b0, `CMD_REF_SETUP, 4'b0000, 16'h0000);
    check("ref_on", ref_enable, 1'b1);
  endtask

  task automatic t_refuse();
    axi_wr(`REG_COMMAND, {8'h00, `CMD_WRITE_UPDATE, 4'b0001, 16'h7777});
    axi_wr(`REG_COMMAND, {8'h00, `CMD_WRITE_UPDATE, 4'b0001, 16'h2222});
    check("busy_resp", rs, `RESP_SLVERR);
    axi_rd(8'h0C);
    check("unmapped", rs, `RESP_SLVERR);
    idle();
    exp_in[0] = 16'h7777;
    exp_dac[0] = 16'h7777;
    cmp();
  endtask

  initial begin
    exp_in = '0;
    exp_dac = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    t_reset();
    t_addr();
    t_write();
    t_read();
    t_ref();
    t_refuse();
    test_done();
  end

  initial begin
    repeat (60000) @(posedge aclk);
    failures++;
    test_done();
  end
endmodule
`default_nettype wire
